/* File: rtl/psr_pkg.sv */
// Shared constants for the parallel speed reference decoder
package psr_pkg;

   // ----------------------------------------
   // Format codes
   // ----------------------------------------
   localparam logic [2:0] PSR_FMT_PCT_1     = 3'h0;
   localparam logic [2:0] PSR_FMT_PCT_0P1   = 3'h1;
   localparam logic [2:0] PSR_FMT_PCT_0P01  = 3'h2;
   localparam logic [2:0] PSR_FMT_HZ_1      = 3'h3;
   localparam logic [2:0] PSR_FMT_HZ_0P1    = 3'h4;
   localparam logic [2:0] PSR_FMT_HZ_0P01   = 3'h5;
   localparam logic [2:0] PSR_FMT_BCD5      = 3'h6;
   localparam logic [2:0] PSR_FMT_BINARY    = 3'h7;

   // ----------------------------------------
   // Widths and field positions
   // ----------------------------------------
   localparam int PSR_WIDE_LINES   = 16;
   localparam int PSR_NARROW_LINES = 8;
   localparam int PSR_MAG_W        = 17;
   localparam int PSR_DIGIT_W      = 4;
   localparam int PSR_BCD5_TOP_LSB = 15;
   localparam logic [PSR_MAG_W-1:0] PSR_MAG_RESET = 17'h00000;

   // Card width codes
   localparam logic PSR_CARD_NARROW = 1'b0;
   localparam logic PSR_CARD_WIDE   = 1'b1;
   // Width switch codes
   localparam logic PSR_SW_12BIT    = 1'b0;
   localparam logic PSR_SW_16BIT    = 1'b1;

endpackage : psr_pkg

/* File: rtl/psr_bcd_digit.sv */
// One BCD digit weighting stage
`timescale 1ns/1ps

module psr_bcd_digit #(
   parameter int ACC_W = 17
) (
   // Digit input
   input  wire logic [3:0]       digit,
   // Accumulated value of higher digits
   input  wire logic [ACC_W-1:0] acc_in,
   // Accumulated value including this digit
   output logic      [ACC_W-1:0] acc_out
);

   // ----------------------------------------
   // Weighting
   // ----------------------------------------
   // Times ten plus digit, lines weighted 1, 2, 4, 8
   assign acc_out = ACC_W'((acc_in << 3) + (acc_in << 1) + ACC_W'(digit));

endmodule : psr_bcd_digit

/* File: rtl/psr_decoder.sv */
// Parallel speed reference decoder, top level
`timescale 1ns/1ps

module psr_decoder
   import psr_pkg::*;
#(
   parameter int LINES = PSR_WIDE_LINES
) (
   // Clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 arst_n,
   // Configuration
   input  wire logic [2:0]           reference_input_format,
   input  wire logic                 card_is_wide,
   input  wire logic                 width_select_switch,
   // Parallel reference lines
   input  wire logic [LINES-1:0]     data_lines,
   input  wire logic                 direction_line,
   input  wire logic                 read_strobe,
   // Decoded setpoint
   output logic      [PSR_MAG_W-1:0] setpoint_magnitude,
   output logic                      setpoint_reverse,
   output logic      [2:0]           setpoint_unit,
   output logic                      setpoint_full_scale,
   output logic                      setpoint_valid,
   output logic                      format_unsupported
);

   // ----------------------------------------
   // Digit extraction
   // ----------------------------------------
   logic [15:0]          lines16;
   logic [PSR_MAG_W-1:0] acc [0:4];
   logic [3:0]           dig [0:3];
   logic                 bcd5_mode;
   logic                 wide16;

   // Card width and mode qualifiers
   assign lines16 = 16'(data_lines);
   assign wide16  = (card_is_wide == PSR_CARD_WIDE) && (width_select_switch == PSR_SW_16BIT);
   assign bcd5_mode = reference_input_format == PSR_FMT_BCD5;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         dig[i] = lines16[i*PSR_DIGIT_W +: PSR_DIGIT_W];
      end
   end

   // ----------------------------------------
   // BCD chains
   // ----------------------------------------
   // digit chain, most significant digit first
   assign acc[0] = PSR_MAG_RESET;
   // Generate index shared by both chains
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_bcd
         psr_bcd_digit #(.ACC_W(PSR_MAG_W)) u_digit (
            .digit   (dig[3-g]),
            .acc_in  (acc[g]),
            .acc_out (acc[g+1])
         );
      end
   endgenerate

   // ----------------------------------------
   // Five-digit unsigned BCD
   // ----------------------------------------
   // lines shifted: line 0 weighs 2, line 3 weighs 10
   logic [19:0]          bcd5_bits;
   logic [PSR_MAG_W-1:0] b5 [0:5];
   // Top digit only reaches three: direction line and line 15
   // direction line as top digit bit weight 2
   assign bcd5_bits = {2'h0, direction_line, lines16, 1'b0};
   assign b5[0] = PSR_MAG_RESET;
   generate
      for (g = 0; g < 5; g++) begin : g_bcd5
         psr_bcd_digit #(.ACC_W(PSR_MAG_W)) u_digit5 (
            .digit   (bcd5_bits[(4-g)*4 +: 4]),
            .acc_in  (b5[g]),
            .acc_out (b5[g+1])
         );
      end
   endgenerate

   // ----------------------------------------
   // Decode selection
   // ----------------------------------------
   // Decoder result before capture
   logic [PSR_MAG_W-1:0] dec_mag;
   logic                 dec_rev;
   logic                 dec_full;
   logic                 dec_ok;

   // Combinational decode of the presented lines
   always_comb begin
      dec_mag  = PSR_MAG_RESET;
      dec_rev  = 1'b0;
      dec_full = 1'b0;
      dec_ok   = 1'b1;
      dec_rev  = direction_line;
      if (card_is_wide == PSR_CARD_NARROW) begin
         if (reference_input_format == PSR_FMT_BINARY) begin
            dec_mag  = PSR_MAG_W'(lines16[7:0]);
            dec_full = &lines16[7:0];
         end else if (bcd5_mode) begin
            dec_ok  = 1'b0;
            dec_rev = 1'b0;
         end else begin
            // two digits; upper digit weighted as-is up to fifteen
            dec_mag = PSR_MAG_W'(dig[1] * 10 + dig[0]);
         end
      end else begin
         if (reference_input_format == PSR_FMT_BINARY) begin
            if (wide16) begin
               dec_mag  = PSR_MAG_W'(lines16);
               dec_full = &lines16;
            end else begin
               // Twelve-bit setting ignores the top four lines
               dec_mag  = PSR_MAG_W'(lines16[11:0]);
               dec_full = &lines16[11:0];
            end
         end else if (bcd5_mode) begin
            dec_ok   = wide16;
            dec_rev  = 1'b0;
            dec_mag  = wide16 ? b5[5] : PSR_MAG_RESET;
            // all bits set gives full speed
            dec_full = wide16 && (&lines16) && direction_line;
         end else if (wide16) begin
            // four digits on the 16-bit setting
            dec_mag = acc[4];
         end else begin
            // three digits on the 12-bit setting
            dec_mag = PSR_MAG_W'(dig[2] * 100 + dig[1] * 10 + dig[0]);
         end
      end
   end

   // ----------------------------------------
   // Setpoint holding register
   // ----------------------------------------
   logic [PSR_MAG_W-1:0] next_setpoint_magnitude;
   logic                 next_setpoint_reverse;
   logic [2:0]           next_setpoint_unit;
   logic                 next_setpoint_full_scale;
   logic                 next_setpoint_valid;
   logic                 next_format_unsupported;

   always_comb begin
      next_setpoint_magnitude  = setpoint_magnitude;
      next_setpoint_reverse    = setpoint_reverse;
      next_setpoint_unit       = setpoint_unit;
      next_setpoint_full_scale = setpoint_full_scale;
      next_setpoint_valid      = setpoint_valid;
      next_format_unsupported  = format_unsupported;
      if (read_strobe) begin
         next_format_unsupported = !dec_ok;
         // unit follows format code, refused codes included
         next_setpoint_unit      = reference_input_format;
         if (dec_ok) begin
            next_setpoint_magnitude  = dec_mag;
            next_setpoint_reverse    = dec_rev;
            next_setpoint_full_scale = dec_full;
            next_setpoint_valid      = 1'b1;
         end else begin
            // Refused code clears the setpoint; no stale speed is kept
            next_setpoint_magnitude  = PSR_MAG_RESET;
            next_setpoint_reverse    = 1'b0;
            next_setpoint_full_scale = 1'b0;
            next_setpoint_valid      = 1'b0;
         end
      end
   end

   // Output registers, cleared asynchronously
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         setpoint_magnitude  <= PSR_MAG_RESET;
         setpoint_reverse    <= 1'b0;
         setpoint_unit       <= PSR_FMT_PCT_1;
         setpoint_full_scale <= 1'b0;
         setpoint_valid      <= 1'b0;
         format_unsupported  <= 1'b0;
      end else begin
         setpoint_magnitude  <= next_setpoint_magnitude;
         setpoint_reverse    <= next_setpoint_reverse;
         setpoint_unit       <= next_setpoint_unit;
         setpoint_full_scale <= next_setpoint_full_scale;
         setpoint_valid      <= next_setpoint_valid;
         format_unsupported  <= next_format_unsupported;
      end
   end

endmodule : psr_decoder

/* File: testbench/psr_decoder_props.sv */
// Port checks for the speed reference decoder
`timescale 1ns/1ps
module psr_decoder_props
   import psr_pkg::*;
#(parameter int LINES = PSR_WIDE_LINES) (
   // Watched ports
   input wire logic ref_clk, arst_n, card_is_wide, width_select_switch, direction_line, read_strobe,
   input wire logic [2:0] reference_input_format, setpoint_unit,
   input wire logic [LINES-1:0] data_lines,
   input wire logic [PSR_MAG_W-1:0] setpoint_magnitude,
   input wire logic setpoint_reverse, setpoint_full_scale, setpoint_valid, format_unsupported
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // Capture qualifiers
   wire t6 = read_strobe && reference_input_format == PSR_FMT_BCD5;
   wire ok6 = t6 && card_is_wide && width_select_switch;
   wire bin = read_strobe && reference_input_format == PSR_FMT_BINARY;
   a_hold_idle: assert property (!read_strobe |=> $stable({setpoint_magnitude, setpoint_valid}))
      else $error("output moved while idle");
   a_dir_sign: assert property (read_strobe && !t6 |=> setpoint_reverse == $past(direction_line))
      else $error("wrong sign");
   a_bcd5_pos: assert property (t6 |=> !setpoint_reverse)
      else $error("five digit reversed");
   a_bcd5_even: assert property (ok6 |=> setpoint_valid && !setpoint_magnitude[0])
      else $error("five digit odd");
   a_bcd5_refuse: assert property (t6 && !ok6 |=> format_unsupported && !setpoint_valid)
      else $error("code six not refused");
   a_full_bin: assert property (bin && card_is_wide && width_select_switch && &data_lines |=> setpoint_full_scale)
      else $error("no full scale");
   a_unit_copy: assert property (read_strobe |=> setpoint_unit == $past(reference_input_format))
      else $error("unit wrong");
   a_narrow_bin: assert property (bin && !card_is_wide |=> setpoint_magnitude == {9'h000, $past(data_lines[7:0])})
      else $error("narrow binary wrong");
endmodule : psr_decoder_props

bind psr_decoder psr_decoder_props #(.LINES(LINES)) u_props (
   .ref_clk(ref_clk), .arst_n(arst_n), .card_is_wide(card_is_wide), .width_select_switch(width_select_switch),
   .direction_line(direction_line), .read_strobe(read_strobe), .reference_input_format(reference_input_format),
   .setpoint_unit(setpoint_unit), .data_lines(data_lines), .setpoint_magnitude(setpoint_magnitude),
   .setpoint_reverse(setpoint_reverse), .setpoint_full_scale(setpoint_full_scale),
   .setpoint_valid(setpoint_valid), .format_unsupported(format_unsupported));

/* File: testbench/psr_ctrl_model.sv */
// Controller that drives the parallel reference lines
`timescale 1ns/1ps
module psr_ctrl_model (
   // Clock
   input  wire logic        ref_clk,
   // Reference lines
   output logic      [15:0] data_lines     = 16'h0000,
   output logic             direction_line = 1'b0,
   output logic             read_strobe    = 1'b0
);
   // Present one word for a single strobed cycle
   task present(input logic [15:0] v, input logic d);
      @(posedge ref_clk) #1;
      data_lines = v;
      direction_line = d;
      read_strobe = 1'b1;
      @(posedge ref_clk) #1;
      read_strobe = 1'b0;
      // Released lines never show the old word
      data_lines = ~v;
      direction_line = ~d;
   endtask : present
endmodule : psr_ctrl_model

/* File: testbench/tb.sv */
// Self-checking bench for the speed reference decoder
`timescale 1ns/1ps
module tb;
   import psr_pkg::*;
   logic                 ref_clk = 1'b0;
   logic                 arst_n  = 1'b0;
   logic [2:0]           fmt     = 3'h0;
   logic                 wide    = 1'b1;
   logic                 sw      = 1'b1;
   logic [15:0]          lines;
   logic                 dir, stb, rev, full, valid, unsup;
   logic [PSR_MAG_W-1:0] mag;
   logic [2:0]           unit;
   int                   err_count = 0;
   int                   samples_checked = 0;
   always #50 ref_clk = ~ref_clk;
   psr_ctrl_model u_ctrl (.ref_clk(ref_clk), .data_lines(lines), .direction_line(dir), .read_strobe(stb));
   psr_decoder dut (.ref_clk(ref_clk), .arst_n(arst_n), .reference_input_format(fmt), .card_is_wide(wide),
      .width_select_switch(sw), .data_lines(lines), .direction_line(dir), .read_strobe(stb),
      .setpoint_magnitude(mag), .setpoint_reverse(rev), .setpoint_unit(unit), .setpoint_full_scale(full),
      .setpoint_valid(valid), .format_unsupported(unsup));
   // Compare {unit, full, valid, unsup, rev, mag} under a mask
   task chk(input logic [23:0] e, input logic [23:0] m);
      logic [23:0] g;
      g = {unit, full, valid, unsup, rev, mag} & m;
      samples_checked++;
      if (g !== (e & m)) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e & m);
      end
   endtask : chk
   // Signed BCD on both switch widths, every unit code
   task t_bcd();
      for (int c = 0; c < 6; c++) begin
         fmt = 3'(c);
         sw = 1'b1;
         u_ctrl.present(16'h1234, 1'b1);
         chk({3'(c), 4'h5, 17'h004D2}, 24'hFFFFFF);
         sw = 1'b0;
         u_ctrl.present(16'hF567, 1'b0);
         chk({3'(c), 4'h4, 17'h00237}, 24'hFFFFFF);
      end
      $display("test bcd done");
   endtask : t_bcd
   // Binary at both widths
   task t_bin();
      fmt = PSR_FMT_BINARY;
      sw = 1'b1;
      u_ctrl.present(16'hFFFF, 1'b0);
      chk({PSR_FMT_BINARY, 4'hC, 17'h0FFFF}, 24'hFFFFFF);
      sw = 1'b0;
      u_ctrl.present(16'hFABC, 1'b1);
      chk({PSR_FMT_BINARY, 4'h5, 17'h00ABC}, 24'hFFFFFF);
      $display("test binary done");
   endtask : t_bin
   // Five digit code, its range edges and refusals
   task t_bcd5();
      fmt = PSR_FMT_BCD5;
      sw = 1'b1;
      u_ctrl.present(16'hCCCC, 1'b1);
      chk({PSR_FMT_BCD5, 4'h4, 17'h09C3E}, 24'hFFFFFF);
      u_ctrl.present(16'h0001, 1'b0);
      chk({PSR_FMT_BCD5, 4'h4, 17'h00002}, 24'hFFFFFF);
      u_ctrl.present(16'hFFFF, 1'b1);
      chk({PSR_FMT_BCD5, 4'hC, 17'h0B648}, 24'hFFFFFF);
      sw = 1'b0;
      u_ctrl.present(16'h1234, 1'b0);
      chk({PSR_FMT_BCD5, 4'h2, 17'h00000}, 24'hEDFFFF);
      wide = 1'b0;
      sw = 1'b1;
      u_ctrl.present(16'h1234, 1'b0);
      chk({PSR_FMT_BCD5, 4'h2, 17'h00000}, 24'hEDFFFF);
      $display("test five digit done");
   endtask : t_bcd5
   // Narrow card binary and two digit BCD, top lines ignored
   task t_narrow();
      fmt = PSR_FMT_BINARY;
      u_ctrl.present(16'h5AFF, 1'b1);
      chk({PSR_FMT_BINARY, 4'hD, 17'h000FF}, 24'hFFFFFF);
      fmt = PSR_FMT_HZ_1;
      u_ctrl.present(16'hA559, 1'b0);
      chk({PSR_FMT_HZ_1, 4'h4, 17'h0003B}, 24'hFFFFFF);
      wide = 1'b1;
      $display("test narrow done");
   endtask : t_narrow
   // Setpoint holds while strobe stays low
   task t_hold();
      fmt = PSR_FMT_PCT_1;
      u_ctrl.present(16'h0042, 1'b1);
      fmt = PSR_FMT_HZ_0P01;
      repeat (3) @(posedge ref_clk);
      #1;
      chk({PSR_FMT_PCT_1, 4'h5, 17'h0002A}, 24'hFFFFFF);
      $display("test hold done");
   endtask : t_hold
   // Mid-run reset clears the setpoint, which then holds with strobe low
   task t_reset();
      u_ctrl.present(16'h0042, 1'b1);
      arst_n = 1'b0;
      #1;
      chk({PSR_FMT_PCT_1, 4'h0, PSR_MAG_RESET}, 24'hFFFFFF);
      @(posedge ref_clk) #1;
      arst_n = 1'b1;
      @(posedge ref_clk) #1;
      chk({PSR_FMT_PCT_1, 4'h0, PSR_MAG_RESET}, 24'hFFFFFF);
      $display("test reset done");
   endtask : t_reset
   // Report counts and verdict
   task give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (20) @(posedge ref_clk);
      #1 arst_n = 1'b1;
      t_bcd();
      t_bin();
      t_bcd5();
      t_narrow();
      t_hold();
      t_reset();
      give_verdict();
   end
endmodule : tb
